// ---- hdl/pcierq_pkg.sv ----
// Shared constants and carrier types for the requester flow and completion block.
package pcierq_pkg;
   localparam int TAG_W = 6;
   localparam int TBL_DEPTH = 64;
   localparam logic [6:0] TBL_FULL = 7'h40;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] NPH_INIT = 8'h03;
   localparam logic [CNT_W-1:0] NPD_INIT = 8'h02;
   localparam logic [1:0] AVAIL_NONE = 2'h0;
   localparam logic [1:0] AVAIL_MANY = 2'h3;
   localparam int ORDER_DEPTH = 2;
   localparam int DESC_BYTES = 12;
   localparam int LADDR_LSB = 0;
   localparam int ERR_LSB = 12;
   localparam int BCNT_LSB = 16;
   localparam int DWCNT_LSB = 0;
   localparam int TAG_LSB = 0;
   localparam logic [10:0] DW_ZERO = 11'h000;
   localparam logic [10:0] DW_ONE = 11'h001;

   typedef struct packed {
      logic is_np;
      logic has_data;
      logic [3:0] seq;
      logic [2:0] addr_offset;
      logic [TAG_W-1:0] tag;
      logic [11:0] addr_lo;
   } pcierq_side_t;

   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic [3:0] err;
      logic [12:0] byte_cnt;
      logic [10:0] dw_cnt;
      logic final_cpl;
   } pcierq_cpl_hdr_t;

   typedef struct packed {
      logic [2:0] addr_offset;
      logic [11:0] addr_lo;
   } pcierq_entry_t;

   typedef enum logic [2:0] {
      S_IDLE, S_D0, S_D1, S_D2, S_PAY
   } pcierq_state_t;
endpackage

// ---- hdl/pcierq_flow.sv ----
// Requester flow control, posted order reporting and completion framing.
//
// Summary of operation
// (R1) A non-posted request may be held off for lack of credit or tags.
// (R2) Two-bit header credit code: none, one, two, three or more.
// (R3) Two-bit data credit code uses the same saturating scheme.
// (R4) Credit codes lag the descriptor beat by two clock cycles.
// (R5) User subtracts credits it spent in the two preceding cycles.
// (R6) Non-posted with payload costs header, data, tag; without, header and tag.
// (R7) Requests leave toward the link in exactly the accepted order.
// (R8) User may give a 4-bit sequence number on the first beat.
// (R9) One-cycle strobe with the sequence number at the no-overtake point.
// (R10) Later completions cannot overtake a posted request once reported.
// (R11) Each completion becomes one packet: 96-bit descriptor, then payload.
// (R12) Dword-aligned mode: payload follows descriptor with no gap.
// (R13) Address-aligned mode: payload next beat, at the offset lane.
// (R14) Address-aligned completions only when requests are address-aligned.
// (R15) Descriptor is 12 bytes, two beats on this 64-bit path.
// (R16) Each split completion is its own packet with its own descriptor.
// (R17) Descriptor bits 11:0 give the stored low byte address.
// (R18) On error only lower address bits 6:0 are valid to the user.
// (R19) The request offset sets the completion data start lane.
// (R20) Pending table holds 64 non-posted requests indexed by tag.
// (R21) Sequence numbers are reported in request acceptance order.
`timescale 1ns/1ps
module pcierq_flow import pcierq_pkg::*; (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic rc_addr_aligned,
   input wire logic rq_addr_aligned,
   input wire logic rq_valid,
   input wire logic rq_first,
   input wire logic rq_last,
   input wire logic [63:0] rq_data,
   input wire pcierq_side_t req_sideband_user,
   output logic rq_ready,
   output logic tx_valid,
   output logic tx_last,
   output logic [63:0] tx_data,
   input wire logic np_hdr_return,
   input wire logic np_data_return,
   output logic [1:0] np_header_credit_avail,
   output logic [1:0] np_data_credit_avail,
   output logic posted_order_tag_strobe,
   output logic [3:0] posted_order_tag_out,
   input wire logic cpl_hdr_valid,
   input wire pcierq_cpl_hdr_t cpl_hdr,
   output logic cpl_hdr_ready,
   input wire logic cpl_dw_valid,
   input wire logic [31:0] cpl_dw,
   output logic cpl_dw_ready,
   output logic rc_valid,
   input wire logic rc_ready,
   output logic [63:0] rc_data,
   output logic [1:0] rc_keep,
   output logic rc_last
);

   function automatic logic [1:0] sat_code(input logic [CNT_W-1:0] c);
      sat_code = (c >= CNT_W'(AVAIL_MANY)) ? AVAIL_MANY : c[1:0]; // R2 R3
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Request side: credits, tags, pass-through and order reporting.
   logic rq_take;
   logic np_take;
   logic p_take;
   logic [CNT_W-1:0] hdr_cnt_ff, nxt_hdr_cnt;
   logic [CNT_W-1:0] dat_cnt_ff, nxt_dat_cnt;
   logic [6:0] outst_ff, nxt_outst;
   logic in_pkt_ff, nxt_in_pkt;
   logic rq_ready_ff, nxt_rq_ready;
   logic [1:0] nph_ff, nxt_nph, npd_ff, nxt_npd;
   logic tx_valid_ff, tx_last_ff;
   logic [63:0] tx_data_ff;
   logic [ORDER_DEPTH:0] ord_vld_ff, nxt_ord_vld;
   logic [3:0] ord_seq_ff [ORDER_DEPTH+1];
   logic tag_free;
   pcierq_entry_t tbl [TBL_DEPTH];

   assign rq_take = rq_valid && rq_ready_ff;
   assign np_take = rq_take && rq_first && req_sideband_user.is_np;
   assign p_take = rq_take && rq_first && !req_sideband_user.is_np;
   logic cpl_retire;

   always_comb begin
      nxt_hdr_cnt = hdr_cnt_ff + CNT_W'(np_hdr_return) - CNT_W'(np_take); // R6
      nxt_dat_cnt = dat_cnt_ff + CNT_W'(np_data_return)
         - CNT_W'(np_take && req_sideband_user.has_data); // R6
      nxt_outst = outst_ff + 7'(np_take) - 7'(cpl_retire); // R20
      nxt_in_pkt = rq_take ? !rq_last : in_pkt_ff;
      tag_free = nxt_outst < TBL_FULL;
      // Head of line is held for any beginning packet until credit exists.
      nxt_rq_ready = nxt_in_pkt || (nxt_hdr_cnt != '0 && nxt_dat_cnt != '0
         && tag_free); // R1
      nxt_nph = sat_code(hdr_cnt_ff); // R4
      nxt_npd = sat_code(dat_cnt_ff); // R4
      nxt_ord_vld = {ord_vld_ff[ORDER_DEPTH-1:0], p_take}; // R9 R21
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         hdr_cnt_ff <= NPH_INIT;
         dat_cnt_ff <= NPD_INIT;
         outst_ff <= '0;
         in_pkt_ff <= 1'b0;
         rq_ready_ff <= 1'b0;
         nph_ff <= AVAIL_NONE;
         npd_ff <= AVAIL_NONE;
         tx_valid_ff <= 1'b0;
         tx_last_ff <= 1'b0;
         tx_data_ff <= '0;
         ord_vld_ff <= '0;
         for (int i = 0; i <= ORDER_DEPTH; i++) begin
            ord_seq_ff[i] <= '0;
         end
      end else if (clk_en) begin
         hdr_cnt_ff <= nxt_hdr_cnt;
         dat_cnt_ff <= nxt_dat_cnt;
         outst_ff <= nxt_outst;
         in_pkt_ff <= nxt_in_pkt;
         rq_ready_ff <= nxt_rq_ready;
         nph_ff <= nxt_nph;
         npd_ff <= nxt_npd;
         tx_valid_ff <= rq_take; // R7
         tx_last_ff <= rq_take && rq_last;
         tx_data_ff <= rq_take ? rq_data : tx_data_ff;
         ord_vld_ff <= nxt_ord_vld;
         ord_seq_ff[0] <= req_sideband_user.seq; // R8
         for (int i = 1; i <= ORDER_DEPTH; i++) begin
            ord_seq_ff[i] <= ord_seq_ff[i-1]; // R21
         end
      end
   end

   always_ff @(posedge clock) begin
      if (clk_en && np_take) begin
         tbl[req_sideband_user.tag] <= {req_sideband_user.addr_offset,
            req_sideband_user.addr_lo}; // R20 R19
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Completion side: descriptor and payload framing onto 64-bit beats.
   pcierq_state_t st_ff, nxt_st;
   pcierq_cpl_hdr_t hdr_ff, nxt_hdr;
   pcierq_entry_t ent_ff, nxt_ent;
   logic [10:0] left_ff, nxt_left;
   logic lane_ff, nxt_lane;
   logic [63:0] bt_data_ff, nxt_bt_data;
   logic [1:0] bt_keep_ff, nxt_bt_keep;
   logic bt_valid_ff, nxt_bt_valid;
   logic bt_last_ff, nxt_bt_last;
   logic hdr_rdy_ff, nxt_hdr_rdy;
   logic dw_rdy_ff, nxt_dw_rdy;
   logic fin_ff, nxt_fin;
   logic aligned;
   logic put;
   logic put_lane;
   logic put_close;
   logic put_last;
   logic [31:0] put_dw;
   logic [95:0] desc;

   assign aligned = rc_addr_aligned && rq_addr_aligned; // R14
   assign cpl_retire = bt_valid_ff && rc_ready && bt_last_ff && fin_ff;

   always_comb begin
      desc = '0;
      desc[LADDR_LSB +: 12] = ent_ff.addr_lo; // R17
      desc[ERR_LSB +: 4] = hdr_ff.err;
      desc[BCNT_LSB +: 13] = hdr_ff.byte_cnt;
      desc[32 + DWCNT_LSB +: 11] = hdr_ff.dw_cnt;
      desc[64 + TAG_LSB +: TAG_W] = hdr_ff.tag;
      nxt_st = st_ff;
      nxt_hdr = hdr_ff;
      nxt_ent = ent_ff;
      nxt_left = left_ff;
      nxt_lane = lane_ff;
      nxt_fin = fin_ff;
      put = 1'b0;
      put_lane = 1'b0;
      put_close = 1'b0;
      put_last = 1'b0;
      put_dw = '0;
      unique case (st_ff)
         S_IDLE: begin
            if (cpl_hdr_valid && hdr_rdy_ff) begin // R16
               nxt_hdr = cpl_hdr;
               nxt_ent = tbl[cpl_hdr.tag];
               nxt_left = cpl_hdr.dw_cnt;
               nxt_fin = cpl_hdr.final_cpl;
               nxt_st = S_D0;
            end
         end
         S_D0: begin
            if (!bt_valid_ff) begin // R11 R15
               put = 1'b1;
               put_dw = desc[31:0];
               nxt_st = S_D1;
            end
         end
         S_D1: begin
            if (!bt_valid_ff) begin // R15
               put = 1'b1;
               put_lane = 1'b1;
               put_close = 1'b1;
               put_dw = desc[63:32];
               nxt_st = S_D2;
            end
         end
         S_D2: begin
            if (!bt_valid_ff) begin
               put = 1'b1;
               put_dw = desc[95:64];
               put_last = left_ff == DW_ZERO;
               put_close = aligned || put_last; // R13
               nxt_lane = aligned ? ent_ff.addr_offset[0] : 1'b1; // R12 R19
               nxt_st = put_last ? S_IDLE : S_PAY;
            end
         end
         S_PAY: begin
            if (cpl_dw_valid && dw_rdy_ff) begin
               put = 1'b1;
               put_lane = lane_ff;
               put_dw = cpl_dw;
               put_last = left_ff == DW_ONE;
               put_close = lane_ff || put_last;
               nxt_lane = !lane_ff;
               nxt_left = left_ff - DW_ONE;
               nxt_st = put_last ? S_IDLE : S_PAY;
            end
         end
      endcase
      nxt_bt_data = bt_data_ff;
      nxt_bt_keep = bt_keep_ff;
      nxt_bt_valid = bt_valid_ff;
      nxt_bt_last = bt_last_ff;
      if (bt_valid_ff && rc_ready) begin
         nxt_bt_valid = 1'b0;
         nxt_bt_keep = '0;
         nxt_bt_last = 1'b0;
      end
      if (put) begin
         nxt_bt_data[put_lane*32 +: 32] = put_dw;
         nxt_bt_keep[put_lane] = 1'b1;
         nxt_bt_valid = put_close;
         nxt_bt_last = put_last;
      end
      nxt_hdr_rdy = nxt_st == S_IDLE && !nxt_bt_valid;
      nxt_dw_rdy = nxt_st == S_PAY && !nxt_bt_valid;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= S_IDLE;
         hdr_ff <= '0;
         ent_ff <= '0;
         left_ff <= '0;
         lane_ff <= 1'b0;
         fin_ff <= 1'b0;
         bt_data_ff <= '0;
         bt_keep_ff <= '0;
         bt_valid_ff <= 1'b0;
         bt_last_ff <= 1'b0;
         hdr_rdy_ff <= 1'b0;
         dw_rdy_ff <= 1'b0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
         hdr_ff <= nxt_hdr;
         ent_ff <= nxt_ent;
         left_ff <= nxt_left;
         lane_ff <= nxt_lane;
         fin_ff <= nxt_fin;
         bt_data_ff <= nxt_bt_data;
         bt_keep_ff <= nxt_bt_keep;
         bt_valid_ff <= nxt_bt_valid;
         bt_last_ff <= nxt_bt_last;
         hdr_rdy_ff <= nxt_hdr_rdy;
         dw_rdy_ff <= nxt_dw_rdy;
      end
   end

   assign rq_ready = rq_ready_ff;
   assign tx_valid = tx_valid_ff;
   assign tx_last = tx_last_ff;
   assign tx_data = tx_data_ff;
   assign np_header_credit_avail = nph_ff;
   assign np_data_credit_avail = npd_ff;
   assign posted_order_tag_strobe = ord_vld_ff[ORDER_DEPTH]; // R10
   assign posted_order_tag_out = ord_seq_ff[ORDER_DEPTH];
   assign cpl_hdr_ready = hdr_rdy_ff;
   assign cpl_dw_ready = dw_rdy_ff;
   assign rc_valid = bt_valid_ff;
   assign rc_data = bt_data_ff;
   assign rc_keep = bt_keep_ff;
   assign rc_last = bt_last_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   a_np_credit_stall: assert property (@(posedge clock) disable iff (sys_rst)
      np_take |-> hdr_cnt_ff != '0 && dat_cnt_ff != '0) // R1
      else $error("non-posted request taken without credit");
   a_hdr_code_lag: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && $past(clk_en) |=> nph_ff == sat_code($past(hdr_cnt_ff))) // R2 R4
      else $error("header credit code wrong");
   a_data_code_lag: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && !np_data_return && np_take && req_sideband_user.has_data
      && dat_cnt_ff == 8'h01 ##1 clk_en ##1 clk_en
      |-> npd_ff == AVAIL_NONE) // R3 R4 R6
      else $error("data credit code did not reach zero two cycles on");
   a_hdr_consume: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && np_take && !np_hdr_return
      |=> hdr_cnt_ff == $past(hdr_cnt_ff) - 8'h01) // R6
      else $error("header credit not consumed");
   a_tx_order: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && rq_take |=> tx_valid_ff && tx_data_ff == $past(rq_data)) // R7
      else $error("request not passed in order");
   a_seq_report: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && p_take ##1 clk_en ##1 clk_en ##1 clk_en
      |-> posted_order_tag_strobe
      && posted_order_tag_out == $past(req_sideband_user.seq, 3)) // R9 R21
      else $error("sequence number not reported");
   a_desc_low_addr: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && st_ff == S_D0 && !bt_valid_ff
      |=> bt_data_ff[11:0] == $past(ent_ff.addr_lo)) // R17
      else $error("lower address not from table");
   a_align_gap: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && st_ff == S_D2 && !bt_valid_ff && aligned
      |=> bt_valid_ff && bt_keep_ff == 2'h1) // R13
      else $error("aligned payload shares descriptor beat");
   a_dword_pack: assert property (@(posedge clock) disable iff (sys_rst)
      clk_en && st_ff == S_D2 && !bt_valid_ff && !aligned && left_ff != '0
      |=> !bt_valid_ff && st_ff == S_PAY && lane_ff) // R12
      else $error("dword-aligned payload left a gap");
   a_table_bound: assert property (@(posedge clock) disable iff (sys_rst)
      outst_ff <= TBL_FULL) // R20
      else $error("pending table overrun");

endmodule // pcierq_flow

// ---- tb/pcierq_user_model.sv ----
// User logic model that consumes the completion stream and records beats.
`timescale 1ns/1ps
module pcierq_user_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic rc_valid,
   input wire logic [63:0] rc_data,
   input wire logic [1:0] rc_keep,
   input wire logic rc_last,
   output logic rc_ready
);
   logic [66:0] beats[$];
   logic [1:0] ph;

   // While stalled, ready is offered one cycle in three.
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rc_ready <= 1'b0;
         ph <= 2'h0;
      end else begin
         ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
         rc_ready <= !stall || (ph == 2'h2);
         if (rc_valid && rc_ready) begin
            beats.push_back({rc_last, rc_keep, rc_data});
         end
      end
   end
endmodule // pcierq_user_model

// ---- tb/pcierq_flow_tb_top.sv ----
// Self-checking testbench for the requester flow and completion block.
`timescale 1ns/1ps
module pcierq_flow_tb_top import pcierq_pkg::*;;
   logic clock, sys_rst, rc_addr_aligned, rq_addr_aligned, rq_valid;
   logic rq_first, rq_last, rq_ready, tx_valid, tx_last, np_hdr_return;
   logic np_data_return, posted_order_tag_strobe, cpl_hdr_valid;
   logic cpl_hdr_ready, cpl_dw_valid, cpl_dw_ready, rc_valid, rc_ready;
   logic rc_last, stall, clk_en;
   logic [63:0] rq_data, tx_data, rc_data;
   logic [1:0] np_header_credit_avail, np_data_credit_avail, rc_keep;
   logic [3:0] posted_order_tag_out;
   logic [31:0] cpl_dw;
   pcierq_side_t req_sideband_user;
   pcierq_cpl_hdr_t cpl_hdr;
   int fail_count = 0, n_checks = 0, cyc = 0;
   logic [64:0] tx_q[$];
   logic [3:0] sq_q[$];
   int cq[$];
   logic [66:0] exp_b[$];
   logic [64:0] te;

   pcierq_flow pcierq_flow_inst (.clock(clock), .sys_rst(sys_rst),
      .clk_en(clk_en), .rc_addr_aligned(rc_addr_aligned),
      .rq_addr_aligned(rq_addr_aligned), .rq_valid(rq_valid),
      .rq_first(rq_first), .rq_last(rq_last), .rq_data(rq_data),
      .req_sideband_user(req_sideband_user), .rq_ready(rq_ready),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_data(tx_data),
      .np_hdr_return(np_hdr_return), .np_data_return(np_data_return),
      .np_header_credit_avail(np_header_credit_avail),
      .np_data_credit_avail(np_data_credit_avail),
      .posted_order_tag_strobe(posted_order_tag_strobe),
      .posted_order_tag_out(posted_order_tag_out),
      .cpl_hdr_valid(cpl_hdr_valid), .cpl_hdr(cpl_hdr),
      .cpl_hdr_ready(cpl_hdr_ready), .cpl_dw_valid(cpl_dw_valid),
      .cpl_dw(cpl_dw), .cpl_dw_ready(cpl_dw_ready), .rc_valid(rc_valid),
      .rc_ready(rc_ready), .rc_data(rc_data), .rc_keep(rc_keep),
      .rc_last(rc_last));

   pcierq_user_model pcierq_user_model_inst (.clock(clock),
      .sys_rst(sys_rst), .stall(stall), .rc_valid(rc_valid),
      .rc_data(rc_data), .rc_keep(rc_keep), .rc_last(rc_last),
      .rc_ready(rc_ready));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchers on the link side and the order report.
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (tx_valid === 1'b1) begin
         te = tx_q.size() ? tx_q.pop_front() : 65'h0;
         chk("tx_data", te[63:0], tx_data);
         chk("tx_last", te[64], tx_last);
      end
      if (posted_order_tag_strobe === 1'b1) begin
         chk("seq_num", sq_q.size() ? sq_q.pop_front() : 4'hx,
            posted_order_tag_out);
         chk("seq_lag", 2, cyc - (cq.size() ? cq.pop_front() : 0));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Handshake and stimulus helpers.
   task automatic hs(int w);
      logic ok;
      for (int i = 0; i < 300; i++) begin
         ok = (w == 0) ? cpl_hdr_ready : (w == 1) ? cpl_dw_ready : rq_ready;
         @(posedge clock);
         #1;
         if (ok === 1'b1) break;
      end
   endtask

   function automatic pcierq_side_t sb(logic np, logic hd, logic [3:0] sq,
      logic [2:0] of, logic [5:0] tg, logic [11:0] ad);
      return '{np, hd, sq, of, tg, ad};
   endfunction

   task automatic take;
      hs(2);
      tx_q.push_back({rq_last, rq_data});
      if (rq_first && !req_sideband_user.is_np) begin
         sq_q.push_back(req_sideband_user.seq);
         cq.push_back(cyc);
      end
   endtask

   task automatic send(bit f, bit l, pcierq_side_t s, logic [63:0] d);
      rq_valid = 1'b1;
      rq_first = f;
      rq_last = l;
      rq_data = d;
      req_sideband_user = s;
      take();
   endtask

   task automatic feed(logic [5:0] tg, logic [3:0] er, logic [10:0] n,
      bit fin, logic [31:0] base, logic [11:0] a, bit o);
      logic [95:0] d;
      logic [32:0] s[$];
      d = '0;
      d[11:0] = a;
      d[15:12] = er;
      d[28:16] = 13'(n * 4);
      d[42:32] = n;
      d[69:64] = tg;
      for (int i = 0; i < 3; i++) s.push_back({1'b1, d[32*i+:32]});
      if (rc_addr_aligned && n != 0) begin
         s.push_back(33'h0);
         if (o) s.push_back(33'h0);
      end
      for (int i = 0; i < n; i++) s.push_back({1'b1, 32'(base + i)});
      if (s.size() % 2) s.push_back(33'h0);
      for (int i = 0; i < s.size(); i += 2) begin
         exp_b.push_back({i + 2 == s.size(), s[i+1][32], s[i][32],
            s[i+1][31:0], s[i][31:0]});
      end
      cpl_hdr = '{tg, er, 13'(n * 4), n, fin};
      cpl_hdr_valid = 1'b1;
      hs(0);
      cpl_hdr_valid = 1'b0;
      for (int i = 0; i < n; i++) begin
         cpl_dw_valid = 1'b1;
         cpl_dw = base + i;
         hs(1);
      end
      cpl_dw_valid = 1'b0;
   endtask

   task automatic check_rc;
      logic [66:0] e, g;
      logic [63:0] m;
      for (int i = 0; i < 400; i++) begin
         if (pcierq_user_model_inst.beats.size() >= exp_b.size()) break;
         @(posedge clock);
      end
      #1;
      while (exp_b.size()) begin
         e = exp_b.pop_front();
         g = pcierq_user_model_inst.beats.size() ?
            pcierq_user_model_inst.beats.pop_front() : 67'hx;
         m = {{32{e[65]}}, {32{e[64]}}};
         chk("rc_keep", e[65:64], g[65:64]);
         chk("rc_last", e[66], g[66]);
         chk("rc_data", e[63:0] & m, g[63:0] & m);
      end
      chk("rc_extra", 0, pcierq_user_model_inst.beats.size());
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task t_posted;
      send(1, 1, sb(0, 1, 4'h5, 0, 0, 0), 64'h1111);
      send(1, 0, sb(0, 1, 4'ha, 0, 0, 0), 64'h2222);
      send(0, 1, sb(0, 0, 4'h0, 0, 0, 0), 64'h3333);
      send(1, 1, sb(0, 1, 4'h3, 0, 0, 0), 64'h4444);
      rq_valid = 1'b0;
      repeat (6) @(posedge clock);
      #1;
      chk("seq_left", 0, sq_q.size());
      chk("nph_avail", 2'h3, np_header_credit_avail);
      chk("npd_avail", 2'h2, np_data_credit_avail);
      $display("test posted done");
   endtask

   task t_credit;
      send(1, 1, sb(1, 1, 0, 3'h1, 6'h01, 12'h123), 64'ha1);
      send(1, 1, sb(1, 0, 0, 3'h0, 6'h02, 12'h7f0), 64'ha2);
      send(1, 1, sb(1, 1, 0, 3'h0, 6'h03, 12'h044), 64'ha3);
      rq_data = 64'h5555;
      req_sideband_user = sb(0, 1, 4'h9, 0, 0, 0);
      chk("nph_lag", 2'h1, np_header_credit_avail);
      chk("npd_lag", 2'h1, np_data_credit_avail);
      @(posedge clock);
      #1;
      chk("nph_none", 2'h0, np_header_credit_avail);
      chk("npd_none", 2'h0, np_data_credit_avail);
      repeat (3) @(posedge clock);
      #1;
      chk("rq_held", 0, rq_ready);
      np_hdr_return = 1'b1;
      np_data_return = 1'b1;
      @(posedge clock);
      #1;
      np_hdr_return = 1'b0;
      np_data_return = 1'b0;
      take();
      rq_valid = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      chk("nph_back", 2'h1, np_header_credit_avail);
      chk("npd_back", 2'h1, np_data_credit_avail);
      // A returned credit must not count while the clock enable is low.
      clk_en = 1'b0;
      np_hdr_return = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      np_hdr_return = 1'b0;
      clk_en = 1'b1;
      chk("nph_frozen", 2'h1, np_header_credit_avail);
      $display("test credit done");
   endtask

   task t_cpl;
      stall = 1'b1;
      feed(6'h02, 4'h0, 11'd2, 0, 32'ha000_0000, 12'h7f0, 0);
      feed(6'h02, 4'h0, 11'd1, 1, 32'ha100_0000, 12'h7f0, 0);
      check_rc();
      stall = 1'b0;
      rc_addr_aligned = 1'b1;
      feed(6'h01, 4'h0, 11'd2, 1, 32'hb000_0000, 12'h123, 1);
      feed(6'h03, 4'h1, 11'd0, 1, 32'h0, 12'h044, 0);
      check_rc();
      chk("seq_left", 0, sq_q.size());
      $display("test completion done");
   endtask

   initial begin
      sys_rst = 1'b1;
      {rc_addr_aligned, rq_valid, rq_first, rq_last, stall} = '0;
      {np_hdr_return, np_data_return, cpl_hdr_valid, cpl_dw_valid} = '0;
      rq_addr_aligned = 1'b1;
      clk_en = 1'b1;
      rq_data = '0;
      cpl_dw = '0;
      req_sideband_user = '0;
      cpl_hdr = '0;
      repeat (16) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      @(posedge clock);
      #1;
      t_posted();
      t_credit();
      t_cpl();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      end_of_test();
   end
endmodule // pcierq_flow_tb_top
